// ### hw/psl_consts.vh
// constants for the strap latch block: offsets, fields, reset values
// assumes a 32-bit classic wishbone slave with word-aligned registers
// Overview of operation
// - isolate strap caught into control bit 10; high isolates, low default.
// - speed strap caught into control bit 13; high, the default, is 100 Mbps.
// - the caught speed strap also sets the speed abilities of register 4h.
// - duplex strap high, the default, means half duplex; low means full.
// - the decoded duplex value is loaded into control bit 8 at reset.
// - autonegotiation strap high, the default, enables it; low disables it.
// - the autonegotiation strap is stored into control bit 12 at reset.
// - each strap pin is a pulled input in reset and until the strap sample, an output after it.
// - interface select straps caught at reset: 001 RMII, others reserved.
// - station address straps caught: address 0 to 7, bits 4 and 3 zero.
`ifndef PSL_CONSTS_VH
`define PSL_CONSTS_VH
`define PSL_OFF_CTRL      4'h0
`define PSL_OFF_ADV       4'h4
`define PSL_OFF_STAT      4'h8
`define PSL_OFF_PINOUT    4'hC
`define PSL_CTRL_DUPLEX   8
`define PSL_CTRL_ISOLATE  10
`define PSL_CTRL_ANEG     12
`define PSL_CTRL_SPEED    13
`define PSL_ADV_10HD      5
`define PSL_ADV_10FD      6
`define PSL_ADV_100HD     7
`define PSL_ADV_100FD     8
`define PSL_ADV_SELECTOR  5'h01
`define PSL_IF_RMII       3'h1
`define PSL_ADDR_DEFAULT  3'h1
`define PSL_NUM_STRAPS    10
`define PSL_SETTLE_LAST   2'h2
`define PSL_RST_ISOLATE   1'h0
`define PSL_RST_SPEED     1'h1
`define PSL_RST_DUPLEX    1'h0
`define PSL_RST_ANEG      1'h1
`define PSL_RST_ADV       4'hF
`define PSL_RST_PINOUT    10'h000
`endif

// ### hw/psl_sync.v
// two-stage synchroniser for a group of strap pins
// assumes inputs are asynchronous to clk; only stage two is read outside
module psl_sync
(
	input  wire       clk,
	input  wire       rst_n,
	input  wire [9:0] async_in,
	output reg  [9:0] sync_out
);
	reg [9:0] meta;

	// first stage feeds only the second
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta     <= 10'h000;
			sync_out <= 10'h000;
		end
		else
		begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule // psl_sync

// ### hw/psl_latch.v
// strap latch: catches strap pins at reset release into control state
// assumes board pulls or the mac hold strap levels until the sample after rst_n rises
// assumes the bus master holds cyc and stb until it sees ack
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`include "psl_consts.vh"
module psl_latch
(
	input  wire        clk,
	input  wire        rst_n,
	input  wire [31:0] wb_adr_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg         wb_ack_o,
	input  wire        isolate_strap_i,
	output wire        isolate_strap_o,
	output wire        isolate_strap_oe,
	output wire        isolate_strap_pull,
	input  wire        speed_strap_i,
	output wire        speed_strap_o,
	output wire        speed_strap_oe,
	output wire        speed_strap_pull,
	input  wire        duplex_strap_i,
	output wire        duplex_strap_o,
	output wire        duplex_strap_oe,
	output wire        duplex_strap_pull,
	input  wire        autoneg_enable_strap_i,
	output wire        autoneg_enable_strap_o,
	output wire        autoneg_enable_strap_oe,
	output wire        autoneg_enable_strap_pull,
	input  wire [2:0]  if_select_straps_i,
	output wire [2:0]  if_select_straps_o,
	output wire [2:0]  if_select_straps_oe,
	output wire [2:0]  if_select_straps_pull,
	input  wire [2:0]  station_address_straps_i,
	output wire [2:0]  station_address_straps_o,
	output wire [2:0]  station_address_straps_oe,
	output wire [2:0]  station_address_straps_pull,
	output wire        isolate,
	output wire        speed_100,
	output wire        full_duplex,
	output wire        autoneg_enable,
	output wire        rmii_mode,
	output wire [4:0]  station_address
);
	localparam ST_SAMPLE = 1'b0;
	localparam ST_RUN    = 1'b1;

	wire [9:0] pins_raw;
	wire [9:0] pins_sync;
	reg        state;
	reg        ctrl_isolate;
	reg        ctrl_speed;
	reg        ctrl_duplex;
	reg        ctrl_aneg;
	reg [3:0]  adv_caps;
	reg [2:0]  if_sel;
	reg [2:0]  addr_low;
	reg [9:0]  pin_out;
	reg [31:0] next_rdata;
	wire       wb_req;
	wire       wr_ctrl;
	wire       wr_adv;
	wire       wr_pins;
	wire       drive;

	assign pins_raw = {station_address_straps_i, if_select_straps_i,
		autoneg_enable_strap_i, duplex_strap_i, speed_strap_i,
		isolate_strap_i};

	// straps arrive from pins, so they pass two flops first
	psl_sync u_sync
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (pins_raw),
		.sync_out (pins_sync)
	);

	// pins are inputs with pulls until the sample is taken
	assign drive = (state == ST_RUN);
	assign {station_address_straps_oe, if_select_straps_oe,
		autoneg_enable_strap_oe, duplex_strap_oe, speed_strap_oe,
		isolate_strap_oe} = {10{drive}};
	assign {station_address_straps_pull, if_select_straps_pull,
		autoneg_enable_strap_pull, duplex_strap_pull, speed_strap_pull,
		isolate_strap_pull} = {10{~drive}};
	assign {station_address_straps_o, if_select_straps_o,
		autoneg_enable_strap_o, duplex_strap_o, speed_strap_o,
		isolate_strap_o} = pin_out;

	assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_ctrl = wb_req & wb_we_i & (wb_adr_i[3:0] == `PSL_OFF_CTRL)
		& (wb_adr_i[31:4] == 28'h0000000);
	assign wr_adv  = wb_req & wb_we_i & (wb_adr_i[3:0] == `PSL_OFF_ADV)
		& (wb_adr_i[31:4] == 28'h0000000);
	assign wr_pins = wb_req & wb_we_i & (wb_adr_i[3:0] == `PSL_OFF_PINOUT)
		& (wb_adr_i[31:4] == 28'h0000000);

	// sample at the first edge once both sync stages see released reset;
	// the synchroniser clears on reset, so two edges are waited out
	// a small counter is cheaper than a deeper synchroniser chain
	reg [1:0] settle;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			settle <= 2'h0;
			state  <= ST_SAMPLE;
		end
		else
		begin
			case (state)
			ST_SAMPLE:
			begin
				settle <= settle + 2'h1;
				if (settle == `PSL_SETTLE_LAST)
					state <= ST_RUN;
			end
			ST_RUN:
				state <= ST_RUN;
			default:
				state <= ST_SAMPLE;
			endcase
		end
	end

	// strap capture and software writes to the captured control bits
	// capture outranks a bus write landing at the same edge
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_isolate <= `PSL_RST_ISOLATE;
			ctrl_speed   <= `PSL_RST_SPEED;
			ctrl_duplex  <= `PSL_RST_DUPLEX;
			ctrl_aneg    <= `PSL_RST_ANEG;
			adv_caps     <= `PSL_RST_ADV;
			if_sel       <= `PSL_IF_RMII;
			addr_low     <= `PSL_ADDR_DEFAULT;
			pin_out      <= `PSL_RST_PINOUT;
		end
		else if ((state == ST_SAMPLE) && (settle == `PSL_SETTLE_LAST))
		begin
			ctrl_isolate <= pins_sync[0];
			ctrl_speed   <= pins_sync[1];
			ctrl_duplex  <= ~pins_sync[2];
			ctrl_aneg    <= pins_sync[3];
			// 10 Mbps strap withdraws the 100 Mbps abilities
			adv_caps     <= {pins_sync[1], pins_sync[1], 2'h3};
			if_sel       <= pins_sync[6:4];
			addr_low     <= pins_sync[9:7];
		end
		else
		begin
			if (wr_ctrl && wb_sel_i[1])
			begin
				ctrl_duplex  <= wb_dat_i[`PSL_CTRL_DUPLEX];
				ctrl_isolate <= wb_dat_i[`PSL_CTRL_ISOLATE];
				ctrl_aneg    <= wb_dat_i[`PSL_CTRL_ANEG];
				ctrl_speed   <= wb_dat_i[`PSL_CTRL_SPEED];
			end
			if (wr_adv && wb_sel_i[0] && wb_sel_i[1])
				adv_caps <= wb_dat_i[8:5];
			if (wr_pins && wb_sel_i[0])
				pin_out[7:0] <= wb_dat_i[7:0];
			if (wr_pins && wb_sel_i[1])
				pin_out[9:8] <= wb_dat_i[9:8];
		end
	end

	// read mux; unmapped addresses read zero and still ack
	always @*
	begin
		next_rdata = 32'h00000000;
		if (wb_adr_i[31:4] == 28'h0000000)
		begin
			case (wb_adr_i[3:0])
			`PSL_OFF_CTRL:
			begin
				next_rdata[`PSL_CTRL_DUPLEX]  = ctrl_duplex;
				next_rdata[`PSL_CTRL_ISOLATE] = ctrl_isolate;
				next_rdata[`PSL_CTRL_ANEG]    = ctrl_aneg;
				next_rdata[`PSL_CTRL_SPEED]   = ctrl_speed;
			end
			`PSL_OFF_ADV:
				next_rdata[8:0] = {adv_caps, `PSL_ADV_SELECTOR};
			`PSL_OFF_STAT:
				next_rdata[7:0] = {state, 1'b0, if_sel, addr_low};
			`PSL_OFF_PINOUT:
				next_rdata[9:0] = pin_out;
			default:
				next_rdata = 32'h00000000;
			endcase
		end
	end

	// one-cycle ack, dropped the cycle after it is given
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? next_rdata : 32'h00000000;
		end
	end

	assign isolate         = ctrl_isolate;
	assign speed_100       = ctrl_speed;
	assign full_duplex     = ctrl_duplex;
	assign autoneg_enable  = ctrl_aneg;
	assign rmii_mode       = (if_sel == `PSL_IF_RMII);
	assign station_address = {2'h0, addr_low};
endmodule // psl_latch

// ### testbench/psl_board.sv
// board side of the strap pins: pull resistors or a mac driving them
// assumes per-pin order isolate,speed,duplex,autoneg,if_sel,addr from bit0
module psl_board
(
	input  wire [9:0] oe,
	input  wire [9:0] po,
	input  wire       drv_en,
	input  wire [9:0] drv_val,
	output wire [9:0] pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// speed, duplex, autoneg, addr0 pull up; the rest pull down
	localparam logic [9:0] pull_lvl = 10'h08E;
	// a driving mac wins over the weak pulls while the device listens
	assign pin = (oe & po) | (~oe & (drv_en ? drv_val : pull_lvl));
endmodule // psl_board

// ### testbench/psl_latch_monitor.sv
// port checks for the strap latch: bus answer and strap capture
// assumes binding into psl_latch, clk rising, rst_n active low
module psl_check
(
	input wire       clk,
	input wire       rst_n,
	input wire       wb_cyc_i,
	input wire       wb_stb_i,
	input wire       wb_ack_o,
	input wire       isolate_strap_i,
	input wire       isolate_strap_oe,
	input wire       speed_strap_i,
	input wire       duplex_strap_i,
	input wire       autoneg_enable_strap_i,
	input wire [2:0] if_select_straps_i,
	input wire [2:0] station_address_straps_i,
	input wire       isolate,
	input wire       speed_100,
	input wire       full_duplex,
	input wire       autoneg_enable,
	input wire       rmii_mode,
	input wire [4:0] station_address
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// pins still carry straps at the edge before the drivers turn on
	sequence cap;
		$rose(isolate_strap_oe);
	endsequence
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_after_req: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_pins_wait: assert property (
		$rose(rst_n) |-> !isolate_strap_oe[*3] ##1 isolate_strap_oe)
		else $error("pin drive not three edges after release");
	a_isolate_cap: assert property (
		cap |-> isolate == $past(isolate_strap_i))
		else $error("isolate not captured");
	a_speed_cap: assert property (
		cap |-> speed_100 == $past(speed_strap_i))
		else $error("speed not captured");
	a_duplex_cap: assert property (
		cap |-> full_duplex != $past(duplex_strap_i))
		else $error("duplex not decoded");
	a_aneg_cap: assert property (
		cap |-> autoneg_enable == $past(autoneg_enable_strap_i))
		else $error("autoneg not captured");
	a_addr_cap: assert property (
		cap |-> station_address ==
		{2'b00, $past(station_address_straps_i)})
		else $error("address not captured");
	a_if_cap: assert property (
		cap |-> rmii_mode == ($past(if_select_straps_i) == 3'h1))
		else $error("interface select not decoded");
	c_iso: cover property (cap ##0 isolate);
	c_ten: cover property (cap ##0 !speed_100);
	c_ack: cover property (wb_ack_o);
endmodule // psl_check
bind psl_latch psl_check i_chk (.*);

// ### testbench/tb_top.sv
// self-checking bench: strap capture, register reads, pin outputs
// assumes psl_latch, psl_board and the bound checker are compiled
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic        drv_en = 1'b0;
	logic [9:0]  drv_val = 10'h000;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] q;
	wire  [31:0] rdat;
	wire         ack;
	wire  [9:0]  pin, po, oe, pu;
	int          err_total = 0;
	int          compares = 0;
	always #2.5 clk = ~clk;
	psl_board i_board (.oe(oe), .po(po), .drv_en(drv_en),
		.drv_val(drv_val), .pin(pin));
	psl_latch i_dut (.clk(clk), .rst_n(rst_n), .wb_adr_i({24'h000000, adr}),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
		.isolate_strap_i(pin[0]), .isolate_strap_o(po[0]),
		.isolate_strap_oe(oe[0]), .isolate_strap_pull(pu[0]),
		.speed_strap_i(pin[1]), .speed_strap_o(po[1]),
		.speed_strap_oe(oe[1]), .speed_strap_pull(pu[1]),
		.duplex_strap_i(pin[2]), .duplex_strap_o(po[2]),
		.duplex_strap_oe(oe[2]), .duplex_strap_pull(pu[2]),
		.autoneg_enable_strap_i(pin[3]), .autoneg_enable_strap_o(po[3]),
		.autoneg_enable_strap_oe(oe[3]), .autoneg_enable_strap_pull(pu[3]),
		.if_select_straps_i(pin[6:4]), .if_select_straps_o(po[6:4]),
		.if_select_straps_oe(oe[6:4]), .if_select_straps_pull(pu[6:4]),
		.station_address_straps_i(pin[9:7]),
		.station_address_straps_o(po[9:7]),
		.station_address_straps_oe(oe[9:7]),
		.station_address_straps_pull(pu[9:7]),
		.isolate(), .speed_100(), .full_duplex(), .autoneg_enable(),
		.rmii_mode(), .station_address());
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one classic cycle; request held until ack is seen at an edge
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		we <= w;
		wdat <= d;
		cyc <= 1'b1;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h00000000);
		chk(q, exp);
	endtask
	// straps must hold until well past release, so drv stays put
	task boot(input logic de, input logic [9:0] dv);
		@(posedge clk);
		rst_n <= 1'b0;
		drv_en <= de;
		drv_val <= dv;
		repeat (3) @(posedge clk);
		chk({22'h000000, oe}, 32'h00000000);
		chk({22'h000000, pu}, 32'h000003FF);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		boot(1'b1, 10'h391);
		rd(8'h00, 32'h00000500);
		rd(8'h04, 32'h00000061);
		rd(8'h08, 32'h0000008F);
		rd(8'h10, 32'h00000000);
		$display("test strap_opposite done");
		bus(8'h0C, 1'b1, 32'h000002A5);
		@(posedge clk);
		chk({22'h000000, po}, 32'h000002A5);
		chk({22'h000000, oe}, 32'h000003FF);
		rd(8'h00, 32'h00000500);
		$display("test pin_output done");
		boot(1'b0, 10'h000);
		rd(8'h00, 32'h00003000);
		rd(8'h04, 32'h000001E1);
		rd(8'h08, 32'h00000081);
		$display("test strap_default done");
		final_report;
	end
	// the run needs about 45 cycles; this leaves ample slack
	initial
	begin
		#20000;
		err_total = err_total + 1;
		final_report;
	end
endmodule // tb_top
